// ===== rtl/lps_sequencer.sv
// Light and proximity sense sequencer: registers, mode control,
// conversion counter, threshold alarm and interrupt logic.
// Assumes LIGHT_LEVEL comes from the front end on CLK and is stable
// at the end of each conversion; OSC_CLK is asynchronous to CLK.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Function
// - Start powered down, no conversion.
// - Result registers zero after reset.
// - Single-shot converts once, then powers down.
// - Continuous converts back to back until off.
// - Six measurement modes, switchable freely.
// - Oscillator drives 4/8/12/16-bit conversion counter.
// - Light and infrared results unsigned n bits.
// - Proximity drives LED with set current, modulation.
// - Alarm open-drain active low, status readable.
// - Alarm when level leaves threshold window.
// - Alarm needs persisting out-of-window cycles.
// - Four selectable full-scale ranges.
// - First control bits 7..5 select mode.
// - Persistence codes give 1, 4, 8, 16.
// - Alarm holds until first control byte access.
// - Resolution codes give 65536..16 oscillator cycles.
module lps_sequencer #(
    parameter int DW = 16
) (
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          RST,
    // Register port
    input  wire logic [3:0]    ADDR,
    input  wire logic [7:0]    WDATA,
    input  wire logic          WR,
    input  wire logic          WR_CONT,
    input  wire logic          RD,
    output logic      [7:0]    RDATA,
    // Front end
    input  wire logic          OSC_CLK,
    input  wire logic [DW-1:0] LIGHT_LEVEL,
    output logic      [1:0]    SENSE_SEL,
    output logic      [1:0]    RANGE_SEL,
    output logic               CONVERTING,
    // Infrared LED driver
    output logic               IR_LED_DRIVE,
    output logic      [1:0]    IR_LED_CURRENT,
    // Alarm and interrupt
    output logic               ALARM_O,
    output logic               ALARM_OE_N,
    output logic               IRQ
);
    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [7:0]    first_ctrl;
    logic [7:0]    second_ctrl;
    logic [DW-1:0] result;
    logic [DW-1:0] thr_low;
    logic [DW-1:0] thr_high;
    logic          flag;
    logic [1:0]    irq_status;
    logic [1:0]    irq_enable;
    logic [3:0]    last_addr;
    logic [DW-1:0] conv_cnt;
    logic          mod_phase;

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    wire [3:0] wr_addr    = WR_CONT ? last_addr + 4'h1 : ADDR;
    wire       wr_first   = WR && wr_addr == lps_pkg::ADDR_FIRST_CTRL;
    wire       wr_second  = WR && wr_addr == lps_pkg::ADDR_SECOND_CTRL;
    wire       wr_low_l   = WR && wr_addr == lps_pkg::ADDR_LOW_LSB;
    wire       wr_low_h   = WR && wr_addr == lps_pkg::ADDR_LOW_MSB;
    wire       wr_high_l  = WR && wr_addr == lps_pkg::ADDR_HIGH_LSB;
    wire       wr_high_h  = WR && wr_addr == lps_pkg::ADDR_HIGH_MSB;
    wire       wr_ien     = WR && wr_addr == lps_pkg::ADDR_IRQ_ENABLE;
    wire       wr_iclr    = WR && wr_addr == lps_pkg::ADDR_IRQ_CLEAR;
    wire       first_xfer = wr_first || (RD && ADDR == lps_pkg::ADDR_FIRST_CTRL);

    lps_pkg::mode_t mode;
    assign mode = lps_pkg::mode_t'(first_ctrl[lps_pkg::MODE_MSB:lps_pkg::MODE_LSB]);

    wire       running  = mode != lps_pkg::MODE_OFF && mode != lps_pkg::MODE_RESERVED;
    wire       one_shot = !first_ctrl[lps_pkg::MODE_MSB];
    wire [1:0] sense    = first_ctrl[lps_pkg::MODE_LSB+1:lps_pkg::MODE_LSB] - 2'b01;
    wire       is_prx   = running && sense == lps_pkg::SENSE_PRX;
    wire       scheme1  = second_ctrl[lps_pkg::SCHEME_BIT];
    wire [1:0] res_code = second_ctrl[lps_pkg::RES_LSB+1:lps_pkg::RES_LSB];
    wire [1:0] per_code = first_ctrl[1:0];

    // -------------------------------------------------------------------
    // Conversion timing
    // -------------------------------------------------------------------
    logic osc_tick;

    edge_sync osc_sync (
        .clk      (CLK),
        .rst      (RST),
        .async_in (OSC_CLK),
        .rise     (osc_tick)
    );

    // Shift is 4 x code, so the last count is 2^(16-shift)-1.
    wire [4:0]    shift    = {1'b0, res_code, 2'b00};
    wire [DW-1:0] cnt_last = {DW{1'b1}} >> shift;
    wire          conv_end = running && osc_tick && conv_cnt == cnt_last && !wr_first;

    // Ambient and infrared are unsigned n bits; scheme 1 proximity keeps its sign.
    wire          signed_cmp = is_prx && scheme1;
    wire [DW-1:0] shaped_u   = LIGHT_LEVEL >> shift;
    wire [DW-1:0] shaped_s   = DW'($signed(LIGHT_LEVEL) >>> shift);
    wire [DW-1:0] shaped     = signed_cmp ? shaped_s : shaped_u;

    // -------------------------------------------------------------------
    // Threshold window and persistence
    // -------------------------------------------------------------------
    wire above_u = shaped > thr_high;
    wire below_u = shaped < thr_low;
    wire above_s = $signed(shaped) > $signed(thr_high);
    wire below_s = $signed(shaped) < $signed(thr_low);
    wire outside = signed_cmp ? (above_s || below_s) : (above_u || below_u);

    logic [4:0] persist_limit;
    always_comb begin
        unique case (per_code)
            2'b00: persist_limit = lps_pkg::PERSIST_0;
            2'b01: persist_limit = lps_pkg::PERSIST_1;
            2'b10: persist_limit = lps_pkg::PERSIST_2;
            2'b11: persist_limit = lps_pkg::PERSIST_3;
        endcase
    end

    logic alarm_fire;

    persist_filter #(
        .CW (5)
    ) persist (
        .clk     (CLK),
        .rst     (RST),
        .restart (wr_first),
        .sample  (conv_end),
        .outside (outside),
        .limit   (persist_limit),
        .fire    (alarm_fire)
    );

    wire       next_flag   = alarm_fire || (flag && !first_xfer);
    wire [1:0] irq_events  = {alarm_fire, conv_end};
    wire [1:0] next_status = irq_events | (irq_status & ~(wr_iclr ? WDATA[1:0] : 2'b00));

    // -------------------------------------------------------------------
    // Register writes and mode control
    // -------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            first_ctrl <= lps_pkg::CTRL_RESET;
        end else if (wr_first) begin
            first_ctrl <= WDATA & lps_pkg::FIRST_WMASK;
        end else if (conv_end && one_shot) begin
            first_ctrl[lps_pkg::MODE_MSB:lps_pkg::MODE_LSB] <= lps_pkg::MODE_OFF;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            second_ctrl <= lps_pkg::CTRL_RESET;
            thr_low     <= lps_pkg::LOW_RESET;
            thr_high    <= lps_pkg::HIGH_RESET;
            irq_enable  <= 2'b00;
            last_addr   <= 4'h0;
        end else begin
            if (WR) last_addr <= wr_addr;
            if (wr_second) second_ctrl <= WDATA;
            if (wr_low_l) thr_low[7:0] <= WDATA;
            if (wr_low_h) thr_low[15:8] <= WDATA;
            if (wr_high_l) thr_high[7:0] <= WDATA;
            if (wr_high_h) thr_high[15:8] <= WDATA;
            if (wr_ien) irq_enable <= WDATA[1:0];
        end
    end

    // -------------------------------------------------------------------
    // Conversion and result
    // -------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            conv_cnt <= '0;
        end else if (!running || wr_first || wr_second || conv_end) begin
            // A new resolution restarts the count, so it never passes the end.
            conv_cnt <= '0;
        end else if (osc_tick) begin
            conv_cnt <= conv_cnt + {{(DW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            result <= lps_pkg::DATA_RESET;
        end else if (conv_end) begin
            result <= shaped;
        end
    end

    // -------------------------------------------------------------------
    // Alarm, interrupt and outputs
    // -------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flag       <= 1'b0;
            irq_status <= 2'b00;
            ALARM_OE_N <= 1'b1;
            ALARM_O    <= 1'b0;
            IRQ        <= 1'b0;
        end else begin
            flag       <= next_flag;
            irq_status <= next_status;
            ALARM_OE_N <= !next_flag;
            ALARM_O    <= 1'b0;
            IRQ        <= |(next_status & irq_enable);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mod_phase <= 1'b0;
        end else if (!is_prx) begin
            mod_phase <= 1'b0;
        end else if (osc_tick) begin
            mod_phase <= !mod_phase;
        end
    end

    wire led_on = is_prx && (!second_ctrl[lps_pkg::FREQ_BIT] || !mod_phase);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            IR_LED_DRIVE   <= 1'b0;
            IR_LED_CURRENT <= 2'b00;
            RANGE_SEL      <= 2'b00;
            SENSE_SEL      <= lps_pkg::SENSE_ALS;
            CONVERTING     <= 1'b0;
        end else begin
            IR_LED_DRIVE   <= led_on;
            IR_LED_CURRENT <= second_ctrl[lps_pkg::CURRENT_LSB+1:lps_pkg::CURRENT_LSB];
            RANGE_SEL      <= second_ctrl[lps_pkg::RANGE_LSB+1:lps_pkg::RANGE_LSB];
            SENSE_SEL      <= sense;
            CONVERTING     <= running;
        end
    end

    // -------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (ADDR)
            lps_pkg::ADDR_FIRST_CTRL: begin
                rd_mux = first_ctrl;
                rd_mux[lps_pkg::FLAG_BIT] = flag;
            end
            lps_pkg::ADDR_SECOND_CTRL: rd_mux = second_ctrl;
            lps_pkg::ADDR_DATA_LSB:    rd_mux = result[7:0];
            lps_pkg::ADDR_DATA_MSB:    rd_mux = result[15:8];
            lps_pkg::ADDR_LOW_LSB:     rd_mux = thr_low[7:0];
            lps_pkg::ADDR_LOW_MSB:     rd_mux = thr_low[15:8];
            lps_pkg::ADDR_HIGH_LSB:    rd_mux = thr_high[7:0];
            lps_pkg::ADDR_HIGH_MSB:    rd_mux = thr_high[15:8];
            lps_pkg::ADDR_IRQ_STATUS:  rd_mux = {6'h00, irq_status};
            lps_pkg::ADDR_IRQ_ENABLE:  rd_mux = {6'h00, irq_enable};
            default:                   rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= RD ? rd_mux : 8'h00;
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence one_shot_end_s;
        conv_end && one_shot && !wr_first;
    endsequence

    idle_no_conv_a: assert property (@(posedge CLK) disable iff (RST)
        !running |-> !conv_end) else $error("conversion while powered down");
    once_powers_down_a: assert property (@(posedge CLK) disable iff (RST)
        one_shot_end_s |=> mode == lps_pkg::MODE_OFF ##1 !CONVERTING)
        else $error("single shot did not power down");
    cont_keeps_mode_a: assert property (@(posedge CLK) disable iff (RST)
        conv_end && !one_shot && !wr_first |=> mode == $past(mode))
        else $error("continuous mode stopped");
    result_update_a: assert property (@(posedge CLK) disable iff (RST)
        conv_end |=> result == $past(shaped)) else $error("result not stored");
    count_bound_a: assert property (@(posedge CLK) disable iff (RST)
        conv_cnt <= cnt_last) else $error("conversion counter overran");
    led_only_prox_a: assert property (@(posedge CLK) disable iff (RST)
        IR_LED_DRIVE |-> $past(is_prx)) else $error("LED on outside proximity");
    alarm_pin_a: assert property (@(posedge CLK) disable iff (RST)
        alarm_fire |=> !ALARM_OE_N && flag) else $error("alarm pin not driven");
    alarm_hold_a: assert property (@(posedge CLK) disable iff (RST)
        flag && !first_xfer |=> flag) else $error("alarm flag dropped early");
    alarm_clear_a: assert property (@(posedge CLK) disable iff (RST)
        first_xfer && !alarm_fire |=> !flag ##0 ALARM_OE_N)
        else $error("alarm not cleared by first control access");
    persist_gate_a: assert property (@(posedge CLK) disable iff (RST)
        alarm_fire |-> outside && conv_end) else $error("alarm without sample");
endmodule

// ===== rtl/lps_pkg.sv
// Constants shared by the light and proximity sense sequencer.
// Assumes an 8-bit register port and a 16-bit conversion result.
package lps_pkg;

    // -------------------------------------------------------------------
    // Register addresses
    // -------------------------------------------------------------------
    localparam logic [3:0] ADDR_FIRST_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_SECOND_CTRL = 4'h1;
    localparam logic [3:0] ADDR_DATA_LSB    = 4'h2;
    localparam logic [3:0] ADDR_DATA_MSB    = 4'h3;
    localparam logic [3:0] ADDR_LOW_LSB     = 4'h4;
    localparam logic [3:0] ADDR_LOW_MSB     = 4'h5;
    localparam logic [3:0] ADDR_HIGH_LSB    = 4'h6;
    localparam logic [3:0] ADDR_HIGH_MSB    = 4'h7;
    localparam logic [3:0] ADDR_TEST        = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h9;
    localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'hA;
    localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'hB;

    // -------------------------------------------------------------------
    // Field layout and reset values
    // -------------------------------------------------------------------
    localparam int         MODE_MSB      = 7;
    localparam int         MODE_LSB      = 5;
    localparam int         FLAG_BIT      = 2;
    localparam int         SCHEME_BIT    = 7;
    localparam int         FREQ_BIT      = 6;
    localparam int         CURRENT_LSB   = 4;
    localparam int         RES_LSB       = 2;
    localparam int         RANGE_LSB     = 0;
    localparam logic [7:0] FIRST_WMASK   = 8'hE3;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [15:0] LOW_RESET    = 16'h0000;
    localparam logic [15:0] HIGH_RESET   = 16'hFFFF;
    localparam logic [15:0] DATA_RESET   = 16'h0000;
    localparam int         IRQ_DONE      = 0;
    localparam int         IRQ_ALARM     = 1;

    // -------------------------------------------------------------------
    // Operation modes
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF      = 3'b000,
        MODE_ALS_ONCE = 3'b001,
        MODE_IR_ONCE  = 3'b010,
        MODE_PRX_ONCE = 3'b011,
        MODE_RESERVED = 3'b100,
        MODE_ALS_CONT = 3'b101,
        MODE_IR_CONT  = 3'b110,
        MODE_PRX_CONT = 3'b111
    } mode_t;

    typedef enum logic [1:0] {
        SENSE_ALS = 2'b00,
        SENSE_IR  = 2'b01,
        SENSE_PRX = 2'b10
    } sense_t;

    // Persistence counts for codes 00, 01, 10, 11.
    localparam logic [4:0] PERSIST_0 = 5'h01;
    localparam logic [4:0] PERSIST_1 = 5'h04;
    localparam logic [4:0] PERSIST_2 = 5'h08;
    localparam logic [4:0] PERSIST_3 = 5'h10;

    // Result is shifted right by this many bits per resolution step,
    // giving 16, 12, 8 or 4 bits for codes 00 to 11.
    localparam int         RES_STEP   = 4;
    localparam int         FULL_BITS  = 16;

endpackage

// ===== rtl/edge_sync.sv
// Two-flop synchroniser with rising-edge detector.
// Assumes the input is asynchronous to CLK.
`timescale 1ns/1ps
module edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Signal
    input  wire logic async_in,
    output logic      rise
);
    logic meta;
    logic stable;
    logic stable_d;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta     <= 1'b0;
            stable   <= 1'b0;
            stable_d <= 1'b0;
        end else begin
            meta     <= async_in;
            stable   <= meta;
            stable_d <= stable;
        end
    end

    assign rise = stable & ~stable_d;
endmodule

// ===== rtl/persist_filter.sv
// Counts consecutive out-of-window results and fires at the limit.
// Assumes one sample pulse per completed conversion.
`timescale 1ns/1ps
module persist_filter #(
    parameter int CW = 5
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Samples
    input  wire logic          restart,
    input  wire logic          sample,
    input  wire logic          outside,
    input  wire logic [CW-1:0] limit,
    output logic               fire
);
    logic [CW-1:0] run;
    wire  [CW-1:0] run_inc = run + {{(CW-1){1'b0}}, 1'b1};

    assign fire = sample & outside & (run_inc >= limit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run <= '0;
        end else if (restart || (sample && !outside)) begin
            run <= '0;
        end else if (sample && run_inc < limit) begin
            run <= run_inc;
        end
    end
endmodule

// ===== sim/lps_front_model.sv
// Front-end partner: a free-running oscillator and a light level source.
// Assumes the bench sets the scene level and CLK is the host clock.
`timescale 1ns/1ps
module lps_front_model (
    // Clock
    input  wire logic        clk,
    // Scene
    input  wire logic [15:0] scene,
    input  wire logic [1:0]  sense_sel,
    input  wire logic        led_on,
    // Front end
    output logic             osc_clk,
    output logic      [15:0] light_level
);
    // The internal oscillator runs free at a 64 ns period.
    initial osc_clk = 1'b0;
    always #32 osc_clk = ~osc_clk;
    // Reflected light adds to the scene only while the LED is lit.
    always_ff @(posedge clk) begin
        light_level <= scene + ((sense_sel == 2'h2 && led_on) ? 16'h1000 : 16'h0000);
    end
endmodule

// ===== sim/lps_sequencer_tb.sv
// Self-checking bench for the light and proximity sense sequencer.
// Assumes the front-end model in lps_front_model and 4-bit resolution runs, except the 8-bit infrared run in t_once.
`timescale 1ns/1ps
module lps_sequencer_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        wr_cont = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] scene = 16'h0000;
    logic [7:0]  rdata;
    logic        osc_clk;
    logic [15:0] light_level;
    logic [1:0]  sense_sel;
    logic [1:0]  range_sel;
    logic        converting;
    logic        led;
    logic [1:0]  led_cur;
    logic        alarm_o;
    logic        alarm_oe_n;
    logic        irq;
    int          errors = 0;
    int          comparisons = 0;

    always #4 clk = ~clk;

    lps_sequencer dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .WR_CONT(wr_cont), .RD(rd), .RDATA(rdata), .OSC_CLK(osc_clk),
        .LIGHT_LEVEL(light_level), .SENSE_SEL(sense_sel), .RANGE_SEL(range_sel),
        .CONVERTING(converting), .IR_LED_DRIVE(led), .IR_LED_CURRENT(led_cur),
        .ALARM_O(alarm_o), .ALARM_OE_N(alarm_oe_n), .IRQ(irq));

    lps_front_model front (.clk(clk), .scene(scene), .sense_sel(sense_sel),
        .led_on(led), .osc_clk(osc_clk), .light_level(light_level));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        if (errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_bit(string what, logic exp, logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(logic [3:0] a, logic [7:0] d, logic cont);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        wr_cont <= cont;
        @(posedge clk);
        wr <= 1'b0;
        wr_cont <= 1'b0;
    endtask

    task automatic reg_rd(logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic expect_reg(string what, logic [3:0] a, logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check_byte(what, exp, d);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Polls the done status bit and clears it, so each call spans one conversion.
    task automatic wait_done();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 300 && s[0] !== 1'b1; i++) reg_rd(4'h9, s);
        if (s[0] !== 1'b1) begin
            errors++;
            test_done();
        end
        reg_wr(4'hB, 8'h01, 1'b0);
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 600 && converting !== 1'b0; i++) @(posedge clk);
        if (converting !== 1'b0) begin
            errors++;
            test_done();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        check_bit("converting", 1'b0, converting);
        check_bit("alarm_oe_n", 1'b1, alarm_oe_n);
        check_bit("irq", 1'b0, irq);
        reg_wr(4'h2, 8'h55, 1'b0);
        expect_reg("first ctrl", 4'h0, 8'h00);
        expect_reg("data lsb", 4'h2, 8'h00);
        expect_reg("data msb", 4'h3, 8'h00);
        expect_reg("low msb", 4'h5, 8'h00);
        expect_reg("high lsb", 4'h6, 8'hFF);
        expect_reg("unmapped", 4'hF, 8'h00);
    endtask

    task automatic t_single();
        scene <= 16'hABCD;
        reg_wr(4'h1, 8'h0D, 1'b0);
        settle();
        check_byte("range", 8'h01, {6'h00, range_sel});
        reg_wr(4'h0, 8'h20, 1'b0);
        settle();
        check_bit("converting", 1'b1, converting);
        check_byte("sense", 8'h00, {6'h00, sense_sel});
        wait_idle();
        expect_reg("data lsb", 4'h2, 8'h0A);
        expect_reg("data msb", 4'h3, 8'h00);
        expect_reg("mode", 4'h0, 8'h00);
        repeat (300) @(posedge clk);
        check_bit("converting", 1'b0, converting);
        expect_reg("data kept", 4'h2, 8'h0A);
    endtask

    task automatic t_cont();
        scene <= 16'h5000;
        reg_wr(4'hB, 8'h03, 1'b0);
        reg_wr(4'h0, 8'hC0, 1'b0);
        wait_done();
        wait_done();
        check_bit("irq masked", 1'b0, irq);
        check_byte("sense", 8'h01, {6'h00, sense_sel});
        expect_reg("data lsb", 4'h2, 8'h05);
        scene <= 16'h7000;
        wait_done();
        wait_done();
        expect_reg("data new", 4'h2, 8'h07);
        reg_wr(4'h0, 8'h00, 1'b0);
        settle();
        check_bit("converting", 1'b0, converting);
    endtask

    task automatic t_prox();
        scene <= 16'h2000;
        reg_wr(4'h1, 8'h3C, 1'b0);
        reg_wr(4'h0, 8'hE0, 1'b0);
        wait_done();
        wait_done();
        check_bit("led", 1'b1, led);
        check_byte("led current", 8'h03, {6'h00, led_cur});
        check_byte("sense", 8'h02, {6'h00, sense_sel});
        expect_reg("data lsb", 4'h2, 8'h03);
        reg_wr(4'h0, 8'h00, 1'b0);
        settle();
        check_bit("led off", 1'b0, led);
        reg_wr(4'h0, 8'h80, 1'b0);
        settle();
        check_bit("reserved", 1'b0, converting);
    endtask

    task automatic t_alarm();
        logic [7:0] s;
        scene <= 16'hF000;
        reg_wr(4'h1, 8'h0C, 1'b0);
        reg_wr(4'h4, 8'h01, 1'b0);
        reg_wr(4'h4, 8'h00, 1'b1);
        reg_wr(4'h6, 8'h05, 1'b0);
        reg_wr(4'h6, 8'h00, 1'b1);
        expect_reg("high msb", 4'h7, 8'h00);
        reg_wr(4'hB, 8'h03, 1'b0);
        reg_wr(4'hA, 8'h02, 1'b0);
        reg_wr(4'h0, 8'hA1, 1'b0);
        repeat (3) wait_done();
        check_bit("alarm early", 1'b1, alarm_oe_n);
        wait_done();
        settle();
        check_bit("alarm", 1'b0, alarm_oe_n);
        check_bit("alarm data", 1'b0, alarm_o);
        check_bit("irq", 1'b1, irq);
        expect_reg("flag", 4'h0, 8'hA5);
        settle();
        check_bit("alarm cleared", 1'b1, alarm_oe_n);
        reg_wr(4'h0, 8'h00, 1'b0);
        reg_rd(4'h9, s);
        check_bit("status alarm", 1'b1, s[1]);
        reg_wr(4'hB, 8'h02, 1'b0);
        settle();
        check_bit("irq cleared", 1'b0, irq);
    endtask

    task automatic t_signed();
        scene <= 16'hE000;
        reg_wr(4'hB, 8'h03, 1'b0);
        reg_wr(4'h1, 8'h8C, 1'b0);
        reg_wr(4'h4, 8'h00, 1'b0);
        reg_wr(4'h4, 8'h00, 1'b1);
        reg_wr(4'h6, 8'hF0, 1'b0);
        reg_wr(4'h6, 8'hFF, 1'b1);
        reg_wr(4'h0, 8'hE0, 1'b0);
        wait_done();
        settle();
        check_bit("signed alarm", 1'b0, alarm_oe_n);
        expect_reg("signed msb", 4'h3, 8'hFF);
        reg_wr(4'h0, 8'h00, 1'b0);
        settle();
        check_bit("write clears", 1'b1, alarm_oe_n);
    endtask

    task automatic t_once();
        int n;
        n = 0;
        scene <= 16'h1234;
        reg_wr(4'h1, 8'h48, 1'b0);
        reg_wr(4'h0, 8'h40, 1'b0);
        repeat (1900) @(posedge clk);
        check_bit("long conv", 1'b1, converting);
        wait_idle();
        expect_reg("ir once lsb", 4'h2, 8'h12);
        expect_reg("ir once mode", 4'h0, 8'h00);
        reg_wr(4'h1, 8'h4C, 1'b0);
        reg_wr(4'h0, 8'h60, 1'b0);
        settle();
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            #1 n += led;
        end
        check_byte("led duty", 8'h20, 8'(n));
        wait_idle();
        check_bit("prx once led", 1'b0, led);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_single();
        t_cont();
        t_prox();
        t_alarm();
        t_signed();
        t_once();
        test_done();
    end
endmodule
